// *** include/pab_pkg.sv ***
// shared constants and types of the actuation priority and bypass block
package pab_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROT_SEQ_NS = 2000;
  localparam int unsigned PROT_SEQ_CYC =
    (PROT_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_W = 8;
  localparam logic [SEQ_W-1:0] SEQ_ZERO = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 8'h01;
  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(PROT_SEQ_CYC - 1);

  // ==========================================================
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_EVENTS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_GROUPS = 4'hC;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // control fields
  localparam int CTRL_MAN_BYP_EN = 0;
  localparam int CTRL_INTERLOCK_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // event counter fields
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // ==========================================================
  // separation-group voting
  localparam int GROUPS = 4;
  localparam logic [2:0] SET_VOTES = 3'h3;
  localparam logic [2:0] CLR_VOTES = 3'h2;

  // device positions
  localparam logic POS_SAFE = 1'b1;

  // ==========================================================
  // types
  typedef enum logic [1:0] {SRC_NONE, SRC_AUTO, SRC_MANUAL} pab_src_t;
  typedef enum logic [1:0] {ST_NORMAL, ST_SEQUENCE, ST_HELD} pab_seq_t;

  typedef struct packed {
    logic auto_req;
    logic manual_req;
    logic override_sw;
    logic ns_enable_sw;
    logic bypass_sw;
  } pab_sw_t;

  typedef struct packed {
    logic cmd_valid;
    logic cmd_pos;
  } pab_ns_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
  } pab_avs_req_t;

endpackage

// *** core/pab_core.sv ***
// actuation priority, seal-in and operating bypass logic for one division
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module pab_core
  import pab_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire pab_pkg::pab_avs_req_t avs_req_i,
  output logic [pab_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // switches, safety requests and control system
  input wire pab_pkg::pab_sw_t sw_i,
  input wire pab_pkg::pab_ns_t ns_i,
  input wire logic [pab_pkg::GROUPS-1:0] group_permit_i,
  // final device and indications
  output logic dev_pos_o,
  output logic sealed_o,
  output pab_pkg::pab_src_t first_src_o,
  output logic ns_enabled_o,
  output logic bypass_o,
  output logic bypass_status_o
);
  import pab_pkg::*;

  localparam int SYNC_W = 5 + 2 + GROUPS;

  // ==========================================================
  // helpers
  function automatic logic [2:0] count4(input logic [GROUPS-1:0] v);
    count4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    sat_inc = (c == CNT_MAX) ? c : c + CNT_ONE;
  endfunction

  // ==========================================================
  // input synchronisers
  wire logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  assign raw_in = {sw_i, ns_i, group_permit_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  wire pab_sw_t sw_s;
  wire pab_ns_t ns_s;
  wire logic [GROUPS-1:0] permit_s;

  assign {sw_s, ns_s, permit_s} = sync_b;

  // edge detection of momentary switches
  logic ns_sw_d;
  logic byp_sw_d;
  wire logic ns_press;
  wire logic byp_press;

  assign ns_press = sw_s.ns_enable_sw & ~ns_sw_d;
  assign byp_press = sw_s.bypass_sw & ~byp_sw_d;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ns_sw_d <= 1'b0;
      byp_sw_d <= 1'b0;
    end
    else
    begin
      ns_sw_d <= sw_s.ns_enable_sw;
      byp_sw_d <= sw_s.bypass_sw;
    end
  end

  // ==========================================================
  // control register
  logic [1:0] ctrl;
  wire logic man_byp_en;
  wire logic interlock_en;

  assign man_byp_en = ctrl[CTRL_MAN_BYP_EN];
  assign interlock_en = ctrl[CTRL_INTERLOCK_EN];

  // ==========================================================
  // protective sequence and seal-in
  pab_seq_t state;
  pab_seq_t next_state;
  logic [SEQ_W-1:0] seq_cnt;
  logic [SEQ_W-1:0] next_seq_cnt;
  pab_src_t first_src;
  pab_src_t next_first_src;

  wire logic raw_req;
  wire logic override_blk;
  wire logic eff_req;
  wire logic held_release;

  assign raw_req = sw_s.auto_req | sw_s.manual_req;
  // override blocks in every state except while the sequence runs
  assign override_blk = sw_s.override_sw & (state != ST_SEQUENCE);
  assign eff_req = raw_req & ~override_blk;
  assign held_release = (state == ST_HELD) & ns_press
    & (sw_s.override_sw | ~raw_req);

  always_comb
  begin
    next_state = state;
    next_seq_cnt = seq_cnt;
    next_first_src = first_src;
    case (state)
      ST_NORMAL:
      begin
        if (eff_req)
        begin
          next_state = ST_SEQUENCE;
          next_seq_cnt = SEQ_ZERO;
          // simultaneous arrival resolves to automatic
          next_first_src = sw_s.auto_req ? SRC_AUTO : SRC_MANUAL;
        end
      end
      ST_SEQUENCE:
      begin
        // no input can leave this state early
        if (seq_cnt == SEQ_LAST)
        begin
          next_state = ST_HELD;
        end
        else
        begin
          next_seq_cnt = seq_cnt + SEQ_ONE;
        end
      end
      ST_HELD:
      begin
        if (held_release)
        begin
          next_state = ST_NORMAL;
          next_first_src = SRC_NONE;
        end
      end
      default:
      begin
        next_state = ST_SEQUENCE;
        next_seq_cnt = SEQ_ZERO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_NORMAL;
      seq_cnt <= SEQ_ZERO;
      first_src <= SRC_NONE;
    end
    else
    begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
      first_src <= next_first_src;
    end
  end

  // ==========================================================
  // nonsafety enable and device position
  logic ns_en;
  logic pos;
  wire logic next_ns_en;
  wire logic next_pos;
  wire logic ns_accept;
  wire logic ns_reject;

  assign next_ns_en = (eff_req || state == ST_SEQUENCE) ? 1'b0
    : (ns_press && (state == ST_NORMAL || held_release)) ? 1'b1
    : (state == ST_HELD) ? 1'b0
    : ns_en;
  assign ns_accept = ns_s.cmd_valid & ns_en & ~eff_req
    & (state == ST_NORMAL);
  assign ns_reject = ns_s.cmd_valid & ~ns_accept;
  assign next_pos = (eff_req || state != ST_NORMAL) ? POS_SAFE
    : ns_accept ? ns_s.cmd_pos
    : pos;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ns_en <= 1'b0;
      pos <= POS_SAFE;
    end
    else
    begin
      ns_en <= next_ns_en;
      pos <= next_pos;
    end
  end

  // ==========================================================
  // operating bypass coincidence
  logic byp;
  wire logic [2:0] valid_votes;
  wire logic [2:0] invalid_votes;
  wire logic byp_permit;
  wire logic byp_drop;
  wire logic byp_request;
  wire logic byp_blocked;
  wire logic next_byp;

  assign valid_votes = count4(permit_s);
  assign invalid_votes = count4(~permit_s);
  assign byp_permit = valid_votes >= SET_VOTES;
  assign byp_drop = invalid_votes >= CLR_VOTES;
  assign byp_request = interlock_en | (man_byp_en & byp_press);
  assign byp_blocked = byp_press & ~byp_permit;
  assign next_byp = byp_drop ? 1'b0
    : (byp_permit && byp_request) ? 1'b1
    : byp;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      byp <= 1'b0;
    end
    else
    begin
      byp <= next_byp;
    end
  end

  // ==========================================================
  // avalon-mm slave
  logic wait_q;
  logic [DATA_W-1:0] rdata;
  logic [CNT_W-1:0] seal_cnt;
  logic [CNT_W-1:0] rej_cnt;
  logic [CNT_W-1:0] blk_cnt;
  wire logic wr_take;
  wire logic rd_load;
  wire logic hit_ctrl;
  wire logic hit_events;
  wire logic [DATA_W-1:0] status_word;
  wire logic [DATA_W-1:0] events_word;
  wire logic [DATA_W-1:0] groups_word;
  wire logic [DATA_W-1:0] read_mux;

  assign wr_take = avs_req_i.write & ~wait_q;
  assign rd_load = avs_req_i.read & wait_q;
  assign hit_ctrl = wr_take & (avs_req_i.address == REG_CTRL);
  assign hit_events = wr_take & (avs_req_i.address == REG_EVENTS);

  assign status_word = {22'h0, byp, override_blk, first_src, state,
    ns_en, pos, (state != ST_NORMAL), raw_req};
  assign events_word = {8'h00, blk_cnt, rej_cnt, seal_cnt};
  assign groups_word = {22'h0, invalid_votes, valid_votes, permit_s};

  assign read_mux = (avs_req_i.address == REG_CTRL) ? {30'h0, ctrl}
    : (avs_req_i.address == REG_STATUS) ? status_word
    : (avs_req_i.address == REG_EVENTS) ? events_word
    : (avs_req_i.address == REG_GROUPS) ? groups_word
    : DATA_ZERO;

  // one wait cycle per access
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_q <= 1'b1;
      rdata <= DATA_ZERO;
    end
    else
    begin
      wait_q <= ~(wait_q & (avs_req_i.read | avs_req_i.write));
      if (rd_load)
      begin
        rdata <= read_mux;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (hit_ctrl)
    begin
      ctrl <= avs_req_i.writedata[1:0];
    end
  end

  // counters: a new event in the clearing cycle still counts
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seal_cnt <= CNT_ZERO;
      rej_cnt <= CNT_ZERO;
      blk_cnt <= CNT_ZERO;
    end
    else
    begin
      if (state == ST_NORMAL && eff_req)
        seal_cnt <= hit_events ? CNT_ONE : sat_inc(seal_cnt);
      else if (hit_events)
        seal_cnt <= CNT_ZERO;
      if (ns_reject)
        rej_cnt <= hit_events ? CNT_ONE : sat_inc(rej_cnt);
      else if (hit_events)
        rej_cnt <= CNT_ZERO;
      if (byp_blocked)
        blk_cnt <= hit_events ? CNT_ONE : sat_inc(blk_cnt);
      else if (hit_events)
        blk_cnt <= CNT_ZERO;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dev_pos_o <= POS_SAFE;
      sealed_o <= 1'b0;
      first_src_o <= SRC_NONE;
      ns_enabled_o <= 1'b0;
      bypass_o <= 1'b0;
      bypass_status_o <= 1'b0;
      avs_readdata_o <= DATA_ZERO;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      dev_pos_o <= next_pos;
      sealed_o <= (next_state != ST_NORMAL);
      first_src_o <= next_first_src;
      ns_enabled_o <= next_ns_en;
      bypass_o <= next_byp;
      bypass_status_o <= next_byp | override_blk;
      avs_readdata_o <= rd_load ? read_mux : rdata;
      avs_waitrequest_o <= ~(wait_q & (avs_req_i.read | avs_req_i.write));
    end
  end

endmodule

`default_nettype wire

// *** tb/pab_panel.sv ***
// operator panel model: one momentary contact closure per press
`timescale 1ns/1ps
`default_nettype none

module pab_panel #(
  parameter int HOLD = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // press request and contact
  input wire logic press_i,
  output var logic sw_o
);
  int cnt;

  // =====================================================
  // contact rests open, closes briefly, reopens by itself
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 0;
    else if (press_i)
      cnt <= HOLD;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign sw_o = (cnt > 0);
endmodule

`default_nettype wire

// *** tb/pab_core_assertions.sv ***
// port assertions of the actuation priority core
`timescale 1ns/1ps
`default_nettype none

module pab_core_assertions
  import pab_pkg::*;
(
  // clock, reset and bus
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire pab_pkg::pab_avs_req_t avs_req_i,
  input wire logic [pab_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // plant side
  input wire pab_pkg::pab_sw_t sw_i,
  input wire pab_pkg::pab_ns_t ns_i,
  input wire logic [pab_pkg::GROUPS-1:0] group_permit_i,
  input wire logic dev_pos_o,
  input wire logic sealed_o,
  input wire pab_pkg::pab_src_t first_src_o,
  input wire logic ns_enabled_o,
  input wire logic bypass_o,
  input wire logic bypass_status_o
);
  wire logic [2:0] n_hi = 3'($countones(group_permit_i));
  wire logic [2:0] n_lo = 3'(GROUPS) - n_hi;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // =====================================================
  // request and vote sequences
  sequence trip_held;
    (sw_i.auto_req && !sw_i.override_sw) [*4];
  endsequence
  sequence lows_held;
    (n_lo >= CLR_VOTES) [*4];
  endsequence

  // =====================================================
  // properties
  wait_answer_a: assert property ((avs_req_i.read || avs_req_i.write)
    && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
  seal_hold_a: assert property (trip_held |-> sealed_o)
    else $error("held trip request not sealed");
  sealed_safe_a: assert property (
    sealed_o |-> dev_pos_o && !ns_enabled_o)
    else $error("sealed but not safe");
  src_first_a: assert property (
    $rose(sealed_o) |-> first_src_o ==
    ($past(sw_i.auto_req, 3) ? SRC_AUTO : SRC_MANUAL))
    else $error("wrong first source recorded");
  ns_press_a: assert property (
    $rose(ns_enabled_o) |->
    $past(sw_i.ns_enable_sw, 3) && !$past(sw_i.ns_enable_sw, 4))
    else $error("nonsafety enabled without a press");
  ns_reject_a: assert property (
    $fell(dev_pos_o) |-> $past(ns_enabled_o) && !sealed_o)
    else $error("nonsafety command acted while not allowed");
  byp_set_a: assert property (
    $rose(bypass_o) |-> $past(n_hi, 3) >= SET_VOTES)
    else $error("bypass set without three permits");
  byp_clear_a: assert property (lows_held |-> !bypass_o)
    else $error("bypass kept with two groups invalid");
  byp_status_a: assert property (bypass_o |-> bypass_status_o)
    else $error("bypass active but not indicated");
endmodule

bind pab_core pab_core_assertions pab_core_assertions_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_req_i(avs_req_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sw_i(sw_i), .ns_i(ns_i), .group_permit_i(group_permit_i),
  .dev_pos_o(dev_pos_o), .sealed_o(sealed_o), .first_src_o(first_src_o),
  .ns_enabled_o(ns_enabled_o), .bypass_o(bypass_o),
  .bypass_status_o(bypass_status_o));

`default_nettype wire

// *** tb/actuation_priority_and_bypass_logic_tb.sv ***
// self-checking bench of the actuation priority core
`timescale 1ns/1ps
`default_nettype none

module actuation_priority_and_bypass_logic_tb;
  import pab_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pab_avs_req_t req = '0;
  pab_ns_t ns = '0;
  logic [GROUPS-1:0] perm = '0;
  logic auto_r = 1'b0;
  logic man_r = 1'b0;
  logic ovr_r = 1'b0;
  logic en_go = 1'b0;
  logic byp_go = 1'b0;
  logic [31:0] rd;
  logic [4:0] rows [8] = '{5'h1F, 5'h1E, 5'h0C, 5'h17, 5'h05, 5'h00,
    5'h1B, 5'h03};
  wire logic [DATA_W-1:0] rdata;
  wire logic wreq, en_sw, byp_sw, dev_pos, sealed, ns_en, byp, byp_st;
  wire pab_src_t src;
  wire pab_sw_t sw = {auto_r, man_r, ovr_r, en_sw, byp_sw};
  int num_errors = 0;
  int check_count = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  pab_core pab_core_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .avs_req_i(req), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .sw_i(sw), .ns_i(ns), .group_permit_i(perm), .dev_pos_o(dev_pos),
    .sealed_o(sealed), .first_src_o(src), .ns_enabled_o(ns_en),
    .bypass_o(byp), .bypass_status_o(byp_st));
  pab_panel en_panel_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .press_i(en_go), .sw_o(en_sw));
  pab_panel byp_panel_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .press_i(byp_go), .sw_o(byp_sw));

  // =====================================================
  // helpers
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // outputs packed: pos sealed ns_en bypass status 0 src
  task automatic co(logic [7:0] e);
    chk("outputs", {24'h0, dev_pos, sealed, ns_en, byp, byp_st, 1'b0, src},
      {24'h0, e});
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk_i);
    req <= '{a, !wr, wr, d};
    do
    begin
      @(posedge sys_clk_i);
      t++;
    end
    while (wreq !== 1'b0 && t < 50);
    rd = rdata;
    req <= '0;
    if (t >= 50)
    begin
      chk("waitrequest", 32'h1, 32'h0);
      give_verdict;
    end
    #1;
  endtask

  task automatic press(logic en);
    @(posedge sys_clk_i);
    en_go <= en;
    byp_go <= !en;
    @(posedge sys_clk_i);
    en_go <= 1'b0;
    byp_go <= 1'b0;
    wt(8);
  endtask

  task automatic sp(logic [3:0] p);
    @(posedge sys_clk_i);
    perm <= p;
    wt(5);
  endtask

  task automatic sr(logic a, logic m, logic o);
    @(posedge sys_clk_i);
    auto_r <= a;
    man_r <= m;
    ovr_r <= o;
    wt(5);
  endtask

  task automatic ns_cmd(logic v, logic p);
    @(posedge sys_clk_i);
    ns <= '{v, p};
    wt(5);
  endtask

  function automatic logic [31:0] exp_groups(logic [3:0] p);
    logic [2:0] n;
    n = 3'(p[0]) + 3'(p[1]) + 3'(p[2]) + 3'(p[3]);
    return {22'h0, 3'h4 - n, n, p};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    wt(5000);
    num_errors++;
    give_verdict;
  end

  // =====================================================
  // tests
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h0000_0003);
    foreach (rows[i])
    begin
      sp(rows[i][3:0]);
      co(rows[i][4] ? 8'h98 : 8'h80);
      bus(1'b0, REG_GROUPS, 32'h0);
      chk("groups", rd, exp_groups(rows[i][3:0]));
    end
    $display("test voting done");
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    sp(4'hF);
    co(8'h80);
    press(1'b1 == 1'b0);
    co(8'h98);
    sp(4'h9);
    co(8'h80);
    bus(1'b1, REG_EVENTS, 32'h0);
    sp(4'h6);
    press(1'b0);
    co(8'h80);
    bus(1'b0, REG_EVENTS, 32'h0);
    chk("blocked", rd, 32'h0001_0000);
    $display("test manual bypass done");
    ns_cmd(1'b1, 1'b0);
    co(8'h80);
    ns_cmd(1'b0, 1'b0);
    sr(1'b1, 1'b1, 1'b0);
    co(8'hC1);
    sr(1'b0, 1'b0, 1'b0);
    press(1'b1);
    co(8'hC1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0056);
    wt(PROT_SEQ_CYC);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0066);
    press(1'b1);
    co(8'hA0);
    ns_cmd(1'b1, 1'b0);
    co(8'h20);
    ns_cmd(1'b1, 1'b1);
    co(8'hA0);
    ns_cmd(1'b1, 1'b0);
    ns_cmd(1'b0, 1'b0);
    co(8'h20);
    sr(1'b0, 1'b1, 1'b0);
    co(8'hC2);
    sr(1'b1, 1'b1, 1'b0);
    co(8'hC2);
    wt(PROT_SEQ_CYC);
    press(1'b1);
    co(8'hC2);
    sr(1'b1, 1'b1, 1'b1);
    press(1'b1);
    co(8'hA8);
    sr(1'b0, 1'b0, 1'b0);
    bus(1'b0, REG_EVENTS, 32'h0);
    chk("seal count", {24'h0, rd[7:0]}, 32'h0000_0002);
    $display("test trips done");
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    wt(2);
    co(8'h80);
    chk("waitrequest", {31'h0, wreq}, 32'h1);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, {30'h0, CTRL_RESET});
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", rd, DATA_ZERO);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0004);
    $display("test reset done");
    give_verdict;
  end
endmodule

`default_nettype wire
